/* File: rtl/cio_pkg.sv */
package cio_pkg;
    // channel count and switch widths
    localparam int unsigned CIO_NCH   = 8;
    localparam int unsigned CIO_DIGW  = 4;
    localparam logic [6:0]  CIO_NODE_MAX = 7'h63; // 99
    // led timing: one flash slot of 200 ms
    localparam int unsigned CIO_CLK_MHZ   = 250;
    localparam int unsigned CIO_SLOT_MS   = 200;
    localparam int unsigned CIO_SLOT_CYC  = CIO_SLOT_MS * CIO_CLK_MHZ * 1000;
    localparam int unsigned CIO_PH_N      = 24; // lcm of blink, single, double periods
    // register byte offsets
    localparam logic [5:0] CIO_A_CFG     = 6'h00;
    localparam logic [5:0] CIO_A_NMT     = 6'h04;
    localparam logic [5:0] CIO_A_ERR     = 6'h08;
    localparam logic [5:0] CIO_A_IN_POL  = 6'h0C;
    localparam logic [5:0] CIO_A_OUT_POL = 6'h10;
    localparam logic [5:0] CIO_A_OUT_VAL = 6'h14;
    localparam logic [5:0] CIO_A_IN_VAL  = 6'h18;
    localparam logic [5:0] CIO_A_COBID   = 6'h1C;
    localparam logic [5:0] CIO_A_IRQ_ST  = 6'h20;
    localparam logic [5:0] CIO_A_IRQ_MSK = 6'h24;
    // config register fields
    localparam int unsigned CIO_F_VALID = 8;
    localparam int unsigned CIO_F_PAIR  = 9;
    localparam int unsigned CIO_F_POK   = 10;
    localparam int unsigned CIO_F_RATE  = 12;
    localparam int unsigned CIO_F_KBPS  = 16;
    localparam int unsigned CIO_F_RXID  = 16;
    // error register fields
    localparam int unsigned CIO_F_WARN  = 0;
    localparam int unsigned CIO_F_GUARD = 1;
    localparam int unsigned CIO_F_BOFF  = 2;
    // interrupt status bits
    localparam int unsigned CIO_IRQ_N    = 3;
    localparam int unsigned CIO_I_INCHG  = 0;
    localparam int unsigned CIO_I_SWCHG  = 1;
    localparam int unsigned CIO_I_AUTO   = 2;
    // reset values
    localparam logic [7:0] CIO_POL_RST = 8'h00;
    localparam logic [7:0] CIO_OUT_RST = 8'h00;
    // process data identifiers
    localparam logic [10:0] CIO_TXPDO_BASE = 11'h180;
    localparam logic [10:0] CIO_RXPDO_BASE = 11'h200;
    // bit rate per switch value modulo 8, kbit/s
    localparam logic [9:0] CIO_KBPS [0:7] = '{10'h00A, 10'h014, 10'h032, 10'h07D,
                                             10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
    typedef enum logic [2:0] {
        CIO_NMT_STOP = 3'b001,
        CIO_NMT_PRE  = 3'b010,
        CIO_NMT_OPER = 3'b100
    } cio_nmt_e;
    typedef enum logic [4:0] {
        CIO_LED_OFF   = 5'b00001,
        CIO_LED_ON    = 5'b00010,
        CIO_LED_BLINK = 5'b00100,
        CIO_LED_SGL   = 5'b01000,
        CIO_LED_DBL   = 5'b10000
    } cio_led_e;
    typedef struct packed {
        logic       pair_ok;
        logic       pair;
        logic       valid;
        logic [2:0] rate;
        logic [9:0] kbps;
        logic [6:0] node;
    } cio_cfg_s;
endpackage : cio_pkg

/* File: rtl/cio_led_flasher.sv */
`timescale 1ns/1ps
`default_nettype none
module cio_led_flasher #(
    parameter int unsigned SLOT_CYC = cio_pkg::CIO_SLOT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire cio_pkg::cio_led_e run_mode,
    input  wire cio_pkg::cio_led_e err_mode,
    output logic                   run_led,
    output logic                   err_led
);
    import cio_pkg::*;
    initial begin
        if (SLOT_CYC < 2) $error("slot too short");
    end
    logic [31:0] slot_ff;
    logic [4:0]  ph_ff;
    logic        slot_end;
    logic        lit_blink;
    logic        lit_sgl;
    logic        lit_dbl;
    assign slot_end = (slot_ff == 32'(SLOT_CYC - 1));
    // slot timer and pattern phase shared by both leds so they stay in step
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slot_ff <= 32'h0;
            ph_ff   <= 5'h0;
        end else if (slot_end) begin
            slot_ff <= 32'h0;
            ph_ff   <= (ph_ff == 5'(CIO_PH_N - 1)) ? 5'h0 : ph_ff + 5'h1;
        end else begin
            slot_ff <= slot_ff + 32'h1;
        end
    end
    // blink 1:1, single 1 on 5 off, double on-off-on then 5 off
    assign lit_blink = ~ph_ff[0];
    assign lit_sgl   = (ph_ff % 5'h6) == 5'h0;
    assign lit_dbl   = ((ph_ff % 5'h8) == 5'h0) || ((ph_ff % 5'h8) == 5'h2);
    function automatic logic pat(input cio_led_e m, input logic b, input logic s, input logic d);
        logic r;
        r = 1'b0;
        case (m)
            CIO_LED_ON:    r = 1'b1;
            CIO_LED_BLINK: r = b;
            CIO_LED_SGL:   r = s;
            CIO_LED_DBL:   r = d;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction : pat
    // registered so the leds never glitch on a mode change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_led <= 1'b0;
            err_led <= 1'b0;
        end else begin
            run_led <= pat(run_mode, lit_blink, lit_sgl, lit_dbl);
            err_led <= pat(err_mode, lit_blink, lit_sgl, lit_dbl);
        end
    end
endmodule : cio_led_flasher
`default_nettype wire

/* File: rtl/cio_node_cfg_status.sv */
// Operation
// - node address is tens switch times ten plus units switch.
// - addresses above 99 or with a non-decimal digit are flagged invalid.
// - rate switch 0..7 means normal mode, 8..F means pairing mode.
// - bit rate comes from the switch value modulo 8, same in both modes.
// - in pairing, partner input ON turns on our same-numbered output.
// - in pairing mode the node goes Operational by itself.
// - run led single flash stopped, blink pre-op, on operational, off in reset.
// - error led off, single flash warning, double flash guard fail, on bus-off.
// - terminator led lights while termination is switched in.
// - output leds show physical output level, after polarity.
// - input leds show physical input level, before polarity.
// - network sets input and output polarity inversion per channel.
// - stack services see node state, identifiers and process data here.
// - eight inputs and eight outputs, each with polarity choice.
// - input polarity is one 8-bit read/write value, reset to zero.
// - input data sent on 180h plus node, outputs taken on 200h plus node.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module cio_node_cfg_status #(
    parameter int unsigned NCH      = cio_pkg::CIO_NCH,
    parameter int unsigned SLOT_CYC = cio_pkg::CIO_SLOT_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [5:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic [cio_pkg::CIO_DIGW-1:0] sw_node_tens,
    input  wire logic [cio_pkg::CIO_DIGW-1:0] sw_node_units,
    input  wire logic [cio_pkg::CIO_DIGW-1:0] sw_rate,
    input  wire logic                         term_en,
    input  wire logic [NCH-1:0]               digital_input_channel,
    output logic [NCH-1:0]                    digital_output_channel,
    output logic [NCH-1:0]                    led_input,
    output logic [NCH-1:0]                    led_output,
    output logic                              led_run,
    output logic                              led_err,
    output logic                              led_term,
    output cio_pkg::cio_cfg_s                 node_cfg,
    output logic                              irq
);
    import cio_pkg::*;
    initial begin
        if (NCH != 8) $error("only eight channels per byte supported");
    end

    // two-stage synchronisers for all pins
    logic [3:0]     tens_s1, tens_s2, units_s1, units_s2, rate_s1, rate_s2;
    logic           term_s1, term_s2;
    logic [NCH-1:0] din_s1, din_s2, din_prev_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {tens_s1, tens_s2, units_s1, units_s2} <= 16'h0000;
            {rate_s1, rate_s2, term_s1, term_s2}   <= 10'h000;
            {din_s1, din_s2, din_prev_ff}          <= '0;
        end else begin
            tens_s1     <= sw_node_tens;
            tens_s2     <= tens_s1;
            units_s1    <= sw_node_units;
            units_s2    <= units_s1;
            rate_s1     <= sw_rate;
            rate_s2     <= rate_s1;
            term_s1     <= term_en;
            term_s2     <= term_s1;
            din_s1      <= digital_input_channel;
            din_s2      <= din_s1;
            din_prev_ff <= din_s2;
        end
    end

    // switch decode
    cio_cfg_s  cfg_ff, nxt_cfg;
    logic [6:0] node_sum;
    assign node_sum = 7'(tens_s2) * 7'h0A + 7'(units_s2);
    always_comb begin
        nxt_cfg       = '0;
        nxt_cfg.node  = node_sum;
        nxt_cfg.valid = (tens_s2 <= 4'h9) && (units_s2 <= 4'h9) && (node_sum != 7'h00)
                        && (node_sum <= CIO_NODE_MAX);
        nxt_cfg.pair  = rate_s2[3];
        nxt_cfg.rate  = rate_s2[2:0];
        nxt_cfg.kbps  = CIO_KBPS[rate_s2[2:0]];
        // odd node pairs upward, so the odd one must leave room for +1
        nxt_cfg.pair_ok = nxt_cfg.valid && rate_s2[3]
                          && (!node_sum[0] || node_sum < CIO_NODE_MAX);
    end
    logic cfg_live_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_ff      <= '0;
            cfg_live_ff <= 1'b0;
        end else begin
            cfg_ff      <= nxt_cfg;
            cfg_live_ff <= 1'b1;
        end
    end
    assign node_cfg = cfg_ff;

    // process data identifiers; pairing listens to the partner's input message
    logic [6:0]  partner;
    logic [10:0] tx_id, rx_id;
    assign partner = cfg_ff.node[0] ? cfg_ff.node + 7'h01 : cfg_ff.node - 7'h01;
    assign tx_id   = CIO_TXPDO_BASE + 11'(cfg_ff.node);
    assign rx_id   = cfg_ff.pair ? CIO_TXPDO_BASE + 11'(partner)
                                 : CIO_RXPDO_BASE + 11'(cfg_ff.node);

    // bus slave: one wait cycle, data registered
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        req, wr_go;
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_go           = avs_write & ack_ff & avs_byteenable[0];
    assign avs_readdata    = rdata_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // polarity, output value and error flags written by the stack
    logic [NCH-1:0] in_pol_ff, out_pol_ff, out_val_ff;
    logic [2:0]     err_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_pol_ff  <= CIO_POL_RST;
            out_pol_ff <= CIO_POL_RST;
            out_val_ff <= CIO_OUT_RST;
            err_ff     <= 3'h0;
        end else if (wr_go) begin
            case (avs_address)
                CIO_A_IN_POL:  in_pol_ff  <= avs_writedata[7:0];
                CIO_A_OUT_POL: out_pol_ff <= avs_writedata[7:0];
                // in pairing the partner's input byte lands here
                CIO_A_OUT_VAL: out_val_ff <= avs_writedata[7:0];
                CIO_A_ERR:     err_ff     <= avs_writedata[2:0];
                default: ;
            endcase
        end
    end

    // network state; pairing starts itself once the switch is seen
    cio_nmt_e nmt_ff;
    logic     auto_done_ff;
    logic     auto_go;
    logic     nmt_wr;
    assign auto_go = cfg_live_ff & cfg_ff.pair & ~auto_done_ff;
    assign nmt_wr  = wr_go && (avs_address == CIO_A_NMT);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmt_ff       <= CIO_NMT_PRE;
            auto_done_ff <= 1'b0;
        end else begin
            auto_done_ff <= cfg_ff.pair & (auto_done_ff | auto_go);
            if (auto_go) begin
                nmt_ff <= CIO_NMT_OPER;
            end else if (nmt_wr) begin
                case (avs_writedata[2:0])
                    CIO_NMT_STOP: nmt_ff <= CIO_NMT_STOP;
                    CIO_NMT_PRE:  nmt_ff <= CIO_NMT_PRE;
                    CIO_NMT_OPER: nmt_ff <= CIO_NMT_OPER;
                    default:      nmt_ff <= nmt_ff;
                endcase
            end
        end
    end

    // physical outputs and channel leds
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            digital_output_channel <= '0;
            led_output             <= '0;
            led_input              <= '0;
            led_term               <= 1'b0;
        end else begin
            digital_output_channel <= out_val_ff ^ out_pol_ff;
            led_output             <= out_val_ff ^ out_pol_ff;
            led_input              <= din_s2;
            led_term               <= term_s2;
        end
    end

    // interrupts: set beats a same-cycle clear
    logic [CIO_IRQ_N-1:0] ist_ff, imsk_ff, iev;
    logic [CIO_IRQ_N-1:0] iclr;
    assign iev[CIO_I_INCHG] = din_s2 != din_prev_ff;
    assign iev[CIO_I_SWCHG] = cfg_live_ff && (nxt_cfg != cfg_ff);
    assign iev[CIO_I_AUTO]  = auto_go;
    assign iclr = (wr_go && avs_address == CIO_A_IRQ_ST) ? avs_writedata[2:0] : '0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ist_ff  <= '0;
            imsk_ff <= '0;
        end else begin
            ist_ff <= (ist_ff & ~iclr) | iev;
            if (wr_go && avs_address == CIO_A_IRQ_MSK) begin
                imsk_ff <= avs_writedata[2:0];
            end
        end
    end
    assign irq = |(ist_ff & imsk_ff);

    // read mux; unmapped addresses read zero
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0;
        case (avs_address)
            CIO_A_CFG: begin
                rmux[6:0]          = cfg_ff.node;
                rmux[CIO_F_VALID]  = cfg_ff.valid;
                rmux[CIO_F_PAIR]   = cfg_ff.pair;
                rmux[CIO_F_POK]    = cfg_ff.pair_ok;
                rmux[CIO_F_RATE+:3] = cfg_ff.rate;
                rmux[CIO_F_KBPS+:10] = cfg_ff.kbps;
            end
            CIO_A_NMT:     rmux[2:0]  = nmt_ff;
            CIO_A_ERR:     rmux[2:0]  = err_ff;
            CIO_A_IN_POL:  rmux[7:0]  = in_pol_ff;
            CIO_A_OUT_POL: rmux[7:0]  = out_pol_ff;
            CIO_A_OUT_VAL: rmux[7:0]  = out_val_ff;
            CIO_A_IN_VAL:  rmux[7:0]  = din_s2 ^ in_pol_ff;
            CIO_A_COBID: begin
                rmux[10:0]            = tx_id;
                rmux[CIO_F_RXID+:11]  = rx_id;
            end
            CIO_A_IRQ_ST:  rmux[2:0]  = ist_ff;
            CIO_A_IRQ_MSK: rmux[2:0]  = imsk_ff;
            default:       rmux       = 32'h0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else if (avs_read & ~ack_ff) begin
            rdata_ff <= rmux;
        end
    end

    // indicator modes; bus-off outranks guarding outranks warning
    cio_led_e run_mode, err_mode;
    always_comb begin
        case (nmt_ff)
            CIO_NMT_STOP: run_mode = CIO_LED_SGL;
            CIO_NMT_PRE:  run_mode = CIO_LED_BLINK;
            CIO_NMT_OPER: run_mode = CIO_LED_ON;
            default:      run_mode = CIO_LED_OFF;
        endcase
        if (err_ff[CIO_F_BOFF]) begin
            err_mode = CIO_LED_ON;
        end else if (err_ff[CIO_F_GUARD]) begin
            err_mode = CIO_LED_DBL;
        end else if (err_ff[CIO_F_WARN]) begin
            err_mode = CIO_LED_SGL;
        end else begin
            err_mode = CIO_LED_OFF;
        end
    end
    cio_led_flasher #(.SLOT_CYC(SLOT_CYC)) u_flash (
        .clk      (clk),
        .rst_n    (rst_n),
        .run_mode (run_mode),
        .err_mode (err_mode),
        .run_led  (led_run),
        .err_led  (led_err)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_node_decode: assert property (cfg_live_ff |=> cfg_ff.node ==
        7'($past(tens_s2, 1)) * 7'h0A + 7'($past(units_s2, 1))) else $error("node decode");
    a_node_max: assert property (cfg_ff.valid |-> cfg_ff.node <= 7'h63)
        else $error("node above 99");
    a_pair_sel: assert property (cfg_live_ff |=>
        cfg_ff.pair == ($past(rate_s2, 1) >= 4'h8)) else $error("mode select");
    a_rate_tbl: assert property (cfg_live_ff |=>
        cfg_ff.kbps == CIO_KBPS[3'($past(rate_s2, 1))]) else $error("bit rate");
    a_auto_oper: assert property (auto_go |=> nmt_ff == CIO_NMT_OPER && auto_done_ff)
        else $error("no auto start");
    a_run_oper: assert property (nmt_ff == CIO_NMT_OPER && !nmt_wr |=> ##1 led_run)
        else $error("run led not on");
    a_err_boff: assert property (err_ff[CIO_F_BOFF] [*2] |-> ##1 led_err)
        else $error("err led not on");
    a_term_led: assert property (term_s2 |=> led_term) else $error("term led");
    a_dout_led: assert property (led_output == digital_output_channel)
        else $error("output led mismatch");
    a_din_led: assert property (##1 led_input == $past(din_s2, 1))
        else $error("input led");
    a_pol_reset: assert property ($rose(rst_n) |-> in_pol_ff == 8'h00)
        else $error("polarity reset");
    a_tx_id: assert property (avs_read && !avs_waitrequest && avs_address == CIO_A_COBID
        |-> avs_readdata[10:0] == 11'h180 + 11'($past(cfg_ff.node, 1))) else $error("tx id");
    a_pair_rx: assert property (cfg_ff.pair |-> rx_id == 11'h180 + 11'(partner))
        else $error("pair rx id");
    a_irq_sticky: assert property (iev[CIO_I_INCHG] |=> ist_ff[CIO_I_INCHG])
        else $error("event lost");
    // bus timing, decode and flag guards
    a_one_wait: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait cycle");
    a_pol_write: assert property (wr_go && avs_address == CIO_A_IN_POL |=>
        in_pol_ff == 8'($past(avs_writedata, 1))) else $error("polarity write");
    a_dout_pol: assert property (##1 digital_output_channel ==
        ($past(out_val_ff, 1) ^ $past(out_pol_ff, 1))) else $error("output polarity");
    a_rx_normal: assert property (!cfg_ff.pair |->
        rx_id == 11'h200 + 11'(cfg_ff.node)) else $error("rx id");
    a_pair_ok: assert property (cfg_ff.pair_ok |-> cfg_ff.valid && cfg_ff.pair)
        else $error("pair ok");
    a_run_stop: assert property (nmt_ff == CIO_NMT_STOP |-> run_mode == CIO_LED_SGL)
        else $error("run single flash");
    a_run_pre: assert property (nmt_ff == CIO_NMT_PRE |-> run_mode == CIO_LED_BLINK)
        else $error("run blink");
    a_err_guard: assert property (err_ff[CIO_F_GUARD] && !err_ff[CIO_F_BOFF]
        |-> err_mode == CIO_LED_DBL) else $error("err double flash");
    a_err_warn: assert property (err_ff == 3'h1 |-> err_mode == CIO_LED_SGL)
        else $error("err single flash");
    a_err_off: assert property (err_ff == 3'h0 |=> !led_err)
        else $error("err led not off");
    a_term_off: assert property (!term_s2 |=> !led_term)
        else $error("term led stuck");
    a_nmt_onehot: assert property ($onehot(nmt_ff))
        else $error("state not one-hot");
    a_set_wins: assert property ((iev != 3'h0) |=> (ist_ff & $past(iev, 1)) == $past(iev, 1))
        else $error("clear beat set");

    // main scenarios
    c_pair_start: cover property (auto_go ##1 nmt_ff == CIO_NMT_OPER);
    c_bus_off: cover property (err_ff[CIO_F_BOFF] && led_err);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_double_flash: cover property (err_mode == CIO_LED_DBL && led_err);
endmodule : cio_node_cfg_status
`default_nettype wire

/* File: sim/cio_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// paired peer module: its node number and its input byte sent as process data
module cio_peer_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] dut_node,
    input  wire logic [7:0] peer_in,
    output logic [6:0]      peer_node,
    output logic [7:0]      peer_pdo
);
    // installer pairs an odd node with the next even one
    assign peer_node = dut_node[0] ? dut_node + 7'h01 : dut_node - 7'h01;
    // pdo byte follows the peer pins one edge later, no inversion on the peer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            peer_pdo <= 8'h00;
        end else begin
            peer_pdo <= peer_in;
        end
    end
endmodule : cio_peer_model
`default_nettype wire

/* File: sim/cio_node_cfg_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module cio_node_cfg_status_tb_top;
    import cio_pkg::*;
    localparam int unsigned SLOT = 4; // short slot keeps led periods at 96 cycles
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [3:0]  sw_node_tens = 4'h3, sw_node_units = 4'h2, sw_rate = 4'h5;
    logic        term_en = 1'b0, led_run, led_err, led_term, irq;
    logic [7:0]  dig_in = 8'h00, dig_out, led_input, led_output, peer_in = 8'h00, peer_pdo;
    logic [6:0]  peer_node;
    cio_cfg_s    node_cfg;
    int          fails = 0, samples_checked = 0, cyc = 0;

    always #2 clk = ~clk;

    cio_node_cfg_status #(.SLOT_CYC(SLOT)) i_cio_node_cfg_status (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sw_node_tens(sw_node_tens),
        .sw_node_units(sw_node_units), .sw_rate(sw_rate), .term_en(term_en),
        .digital_input_channel(dig_in), .digital_output_channel(dig_out),
        .led_input(led_input), .led_output(led_output), .led_run(led_run),
        .led_err(led_err), .led_term(led_term), .node_cfg(node_cfg), .irq(irq));
    cio_peer_model i_cio_peer_model (.clk(clk), .rst_n(rst_n), .dut_node(node_cfg.node),
        .peer_in(peer_in), .peer_node(peer_node), .peer_pdo(peer_pdo));

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // one avalon transfer; request held until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask : rdchk

    task cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // a whole 24-slot period is counted, so the free-running phase does not matter
    task count_led(input logic sel_err, output int c);
        c = 0;
        cycles(4);
        repeat (24 * SLOT) begin
            @(posedge clk);
            c += sel_err ? int'(led_err === 1'b1) : int'(led_run === 1'b1);
        end
    endtask : count_led

    task t_regs;
        rdchk(CIO_A_IN_POL, 32'h0);
        rdchk(CIO_A_OUT_POL, 32'h0);
        rdchk(CIO_A_NMT, 32'h2);
        bus(1'b1, CIO_A_NMT, 32'h3);
        rdchk(CIO_A_NMT, 32'h2);
        bus(1'b1, 6'h3C, 32'hFF);
        rdchk(6'h3C, 32'h0);
        bus(1'b1, CIO_A_IN_POL, 32'h1A5);
        rdchk(CIO_A_IN_POL, 32'hA5);
        avs_byteenable <= 4'h0;
        bus(1'b1, CIO_A_IN_POL, 32'h00);
        avs_byteenable <= 4'h1;
        rdchk(CIO_A_IN_POL, 32'hA5);
    endtask : t_regs

    task t_node;
        logic [3:0] tt [4] = '{4'h3, 4'h9, 4'h0, 4'hA};
        logic [3:0] uu [4] = '{4'h2, 4'h9, 4'h0, 4'h1};
        logic [6:0] nn [4] = '{7'h20, 7'h63, 7'h00, 7'h00};
        logic       vv [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            sw_node_tens  <= tt[i];
            sw_node_units <= uu[i];
            cycles(6);
            `CHK(node_cfg.valid, vv[i])
            if (vv[i]) `CHK(node_cfg.node, nn[i])
        end
        sw_node_tens  <= 4'h3;
        sw_node_units <= 4'h2;
        cycles(6);
        rdchk(CIO_A_COBID, 32'h022001A0);
    endtask : t_node

    task t_leds;
        logic [31:0] nmt [3] = '{32'h1, 32'h4, 32'h2};
        int          rx [3] = '{16, 96, 48};
        logic [31:0] err [4] = '{32'h1, 32'h3, 32'h7, 32'h0};
        int          ex [4] = '{16, 24, 96, 0};
        int          c;
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CIO_A_NMT, nmt[i]);
            count_led(1'b0, c);
            `CHK(c, rx[i])
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CIO_A_ERR, err[i]);
            count_led(1'b1, c);
            `CHK(c, ex[i])
        end
    endtask : t_leds

    task t_io;
        bus(1'b1, CIO_A_OUT_VAL, 32'hA5);
        bus(1'b1, CIO_A_OUT_POL, 32'h0F);
        cycles(3);
        `CHK(dig_out, 8'hAA)
        `CHK(led_output, 8'hAA)
        dig_in <= 8'h3C;
        bus(1'b1, CIO_A_IN_POL, 32'hFF);
        cycles(4);
        `CHK(led_input, 8'h3C)
        rdchk(CIO_A_IN_VAL, 32'hC3);
        term_en <= 1'b1;
        cycles(5);
        `CHK(led_term, 1'b1)
        term_en <= 1'b0;
        cycles(5);
        `CHK(led_term, 1'b0)
    endtask : t_io

    // interrupt raised by an input change, masked, then cleared by writing one
    task t_irq;
        bus(1'b1, CIO_A_IRQ_ST, 32'h7);
        bus(1'b1, CIO_A_IRQ_MSK, 32'h1);
        cycles(1);
        `CHK(irq, 1'b0)
        dig_in <= 8'hC3;
        cycles(5);
        `CHK(irq, 1'b1)
        rdchk(CIO_A_IRQ_ST, 32'h1);
        bus(1'b1, CIO_A_IRQ_MSK, 32'h0);
        cycles(1);
        `CHK(irq, 1'b0)
        bus(1'b1, CIO_A_IRQ_MSK, 32'h1);
        bus(1'b1, CIO_A_IRQ_ST, 32'h1);
        cycles(1);
        `CHK(irq, 1'b0)
    endtask : t_irq

    task t_rate;
        logic [9:0] kb [8] = '{10'h00A, 10'h014, 10'h032, 10'h07D,
                               10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
        sw_node_tens  <= 4'h0;
        sw_node_units <= 4'h1;
        for (int s = 0; s < 16; s++) begin
            sw_rate <= 4'(s);
            cycles(6);
            `CHK(node_cfg.kbps, kb[s % 8])
            `CHK(node_cfg.pair, s[3])
        end
        sw_rate <= 4'hD;
        cycles(6);
        rdchk(CIO_A_NMT, 32'h4);
        rdchk(CIO_A_IRQ_ST, 32'h6);
        `CHK(node_cfg.pair_ok, 1'b1)
        rdchk(CIO_A_COBID, 32'h01820181);
        `CHK(peer_node, 7'h02)
        // stack role: the peer's pdo byte becomes our output byte
        bus(1'b1, CIO_A_OUT_POL, 32'h0);
        peer_in <= 8'h5A;
        cycles(2);
        bus(1'b1, CIO_A_OUT_VAL, {24'h0, peer_pdo});
        cycles(2);
        `CHK(dig_out, 8'h5A)
    endtask : t_rate

    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        cycles(2);
        `CHK(led_run, 1'b0)
        `CHK(dig_out, 8'h00)
        rst_n <= 1'b1;
        cycles(6);
        t_regs();
        t_node();
        t_leds();
        t_io();
        t_irq();
        t_rate();
        end_of_test();
    end
endmodule : cio_node_cfg_status_tb_top
`default_nettype wire
